// [hw/sre_pkg.sv]
// constants and types shared by the speech residual encoder
package sre_pkg;
    // frame and subsegment geometry
    localparam logic [7:0] FRAME_LAST = 8'h9F;
    localparam logic [5:0] SUB_LAST = 6'h27;
    localparam logic [7:0] HIST_LEN = 8'h78;
    localparam logic [6:0] LAG_MIN = 7'h28;
    localparam logic [6:0] LAG_MAX = 7'h78;
    localparam logic [2:0] STAGE_LAST = 3'h7;
    localparam logic [3:0] TAP_LAST = 4'hA;
    localparam logic [7:0] TAP_CENTRE = 8'h05;
    localparam logic [3:0] GRID_LAST = 4'hC;
    localparam logic [5:0] GRID_SPAN = 6'h24;
    localparam logic [5:0] GRID_STRIDE = 6'h03;
    // first sample of coefficient sets 1, 2 and 3 within a frame
    localparam logic [7:0] SET1_START = 8'h0D;
    localparam logic [7:0] SET2_START = 8'h1B;
    localparam logic [7:0] SET3_START = 8'h28;
    localparam int COEF_SHIFT = 15;
    localparam int TAP_SHIFT = 13;
    localparam int GAIN_SHIFT = 15;
    // gain_decision_level as ratios: 0.2 = 1/5, 0.5 = 1/2, 0.8 = 4/5
    localparam logic signed [43:0] DEC0_R = 44'sh5;
    localparam logic signed [43:0] DEC0_S = 44'sh1;
    localparam logic signed [43:0] DEC1_R = 44'sh2;
    localparam logic signed [43:0] DEC1_S = 44'sh1;
    localparam logic signed [43:0] DEC2_R = 44'sh5;
    localparam logic signed [43:0] DEC2_S = 44'sh4;
    // gain_reconstruction_level in Q15: 0.10, 0.35, 0.65, 1.00
    localparam logic signed [15:0] GAIN_LVL0 = 16'sh0CCD;
    localparam logic signed [15:0] GAIN_LVL1 = 16'sh2CCD;
    localparam logic signed [15:0] GAIN_LVL2 = 16'sh5333;
    localparam logic signed [15:0] GAIN_LVL3 = 16'sh7FFF;
    // weighting taps scaled by 2^13, centre outward
    localparam logic signed [15:0] TAP_C0 = 16'sh2000;
    localparam logic signed [15:0] TAP_C1 = 16'sh166D;
    localparam logic signed [15:0] TAP_C2 = 16'sh0806;
    localparam logic signed [15:0] TAP_C3 = 16'sh0000;
    localparam logic signed [15:0] TAP_C4 = 16'shFE8A;
    localparam logic signed [15:0] TAP_C5 = 16'shFF7A;
    typedef logic signed [15:0] sre_smp_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LAT, ST_CORR, ST_ENER, ST_QUANT, ST_LTPF, ST_WEIGHT, ST_OUT
    } sre_state_t;
endpackage

// [hw/sre_speech_residual_encoder.sv]
// speech residual encoder: lattice, long-term predictor, weighting and grid pick
// What this block does
// [R1] eight-stage lattice turns samples into residual
// [R2] 160-sample frame split into four 40-sample subsegments
// [R3] correlate 40 samples for every lag 40..120
// [R4] pitch lag is lag of peak correlation
// [R5] gain is peak correlation over lagged energy
// [R6] keep last 120 reconstructed samples across subsegments
// [R7] lag sent as a 7-bit code
// [R8] gain quantized to 2 bits at 0.2/0.5/0.8
// [R9] gain code decodes to 0.10/0.35/0.65/1.00
// [R10] long-term residual is residual minus estimate
// [R11] estimate uses decoded gain and decoded lag
// [R12] reconstruction adds estimate back, feeds history
// [R13] eleven symmetric weighting taps scaled by 2^13
// [R14] keep 40 central outputs, zero outside subsegment
// [R15] four stride-3 grids of 13 samples each
// [R16] highest-energy grid is passed on
// [R17] grid position sent as 2-bit code
// [R18] four interpolated coefficient sets per frame
// [R19] ties keep the first in ascending order
// [R20] lag code carries lag value in binary
`timescale 1ns/1ps
module sre_speech_residual_encoder (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SAMPLE_VALID,
    input wire sre_pkg::sre_smp_t SAMPLE_IN,
    input wire logic COEF_WE,
    input wire logic [1:0] COEF_SET,
    input wire logic [2:0] COEF_IDX,
    input wire sre_pkg::sre_smp_t COEF_DATA,
    output logic SAMPLE_READY,
    output logic PARAM_VALID,
    output logic [6:0] LAG_CODE,
    output logic [1:0] GAIN_CODE,
    output logic [1:0] GRID_CODE,
    output logic PULSE_VALID,
    output logic PULSE_LAST,
    output sre_pkg::sre_smp_t PULSE_DATA
);
    import sre_pkg::*;

    typedef struct packed {
        sre_state_t st;
        logic rdy;
        logic [7:0] ks;
        logic [2:0] stg;
        logic [15:0] dl;
        logic [15:0] cu;
        logic [7:0][15:0] up;
        logic [31:0][15:0] coef;
        logic [39:0][15:0] db;
        logic [39:0][15:0] eb;
        logic [39:0][15:0] xb;
        logic [119:0][15:0] hist;
        logic [5:0] i;
        logic [6:0] lam;
        logic [6:0] lag;
        logic [3:0] t;
        logic [1:0] ph;
        logic [39:0] acc;
        logic [39:0] best;
        logic [1:0] gc;
        logic [1:0] grid;
        logic [3:0][39:0] en;
        logic param_v;
        logic pv;
        logic plast;
        logic [15:0] pdata;
        logic [3:0] run;
    } sre_reg_t;

    sre_reg_t r;
    sre_reg_t n;

    // clamp a wide signed value to the 16-bit sample range
    function automatic logic [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sh7FFF) begin
            return 16'h7FFF;
        end else if (v < 48'shFFFF_FFFF_8000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    // symmetric weighting taps, index 0..10
    function automatic logic signed [15:0] tap(input logic [3:0] t);
        case (t)
            4'h0, 4'hA: tap = TAP_C5;
            4'h1, 4'h9: tap = TAP_C4;
            4'h2, 4'h8: tap = TAP_C3;
            4'h3, 4'h7: tap = TAP_C2;
            4'h4, 4'h6: tap = TAP_C1;
            default: tap = TAP_C0;
        endcase
    endfunction

    // decoded gain for a 2-bit gain_code
    function automatic logic signed [15:0] gain_lvl(input logic [1:0] c);
        case (c)
            2'h0: gain_lvl = GAIN_LVL0;
            2'h1: gain_lvl = GAIN_LVL1;
            2'h2: gain_lvl = GAIN_LVL2;
            default: gain_lvl = GAIN_LVL3;
        endcase
    endfunction

    logic [1:0] cset;
    logic [7:0] hx;
    logic [7:0] ix;
    logic signed [15:0] ca;
    logic signed [31:0] p;
    logic signed [31:0] q;
    logic signed [39:0] sum;
    logic signed [43:0] rr;
    logic signed [43:0] ss;
    logic [15:0] est;
    logic [15:0] ev;
    logic [15:0] xv;
    logic [1:0] g;

    // next-state logic for the whole datapath
    always_comb begin
        n = r;
        n.param_v = 1'b0;
        n.pv = 1'b0;
        n.plast = 1'b0;
        n.run = r.pv ? r.run + 4'h1 : 4'h0; // pulses seen in a row, for the checks
        p = '0;
        q = '0;
        sum = '0;
        rr = '0;
        ss = '0;
        est = '0;
        ev = '0;
        xv = '0;
        g = 2'h0;
        ca = '0;
        ix = '0;
        // coefficient set by sample position in the frame
        if (r.ks < SET1_START) begin
            cset = 2'h0; // R18
        end else if (r.ks < SET2_START) begin
            cset = 2'h1;
        end else if (r.ks < SET3_START) begin
            cset = 2'h2;
        end else begin
            cset = 2'h3;
        end
        hx = HIST_LEN + 8'(r.i) - 8'((r.st == ST_CORR) ? r.lam : r.lag);
        if (COEF_WE) begin
            n.coef[{COEF_SET, COEF_IDX}] = COEF_DATA;
        end
        case (r.st)
            ST_IDLE: begin
                if (SAMPLE_VALID && r.rdy) begin
                    n.rdy = 1'b0;
                    n.dl = SAMPLE_IN; // R1
                    n.cu = SAMPLE_IN;
                    n.stg = '0;
                    n.st = ST_LAT;
                end
            end
            ST_LAT: begin
                ca = $signed(r.coef[{cset, r.stg}]);
                p = ca * $signed(r.up[r.stg]);
                q = ca * $signed(r.dl);
                n.dl = sat16(48'($signed(r.dl)) + 48'(p >>> COEF_SHIFT)); // R1
                n.cu = sat16(48'($signed(r.up[r.stg])) + 48'(q >>> COEF_SHIFT)); // R1
                n.up[r.stg] = r.cu;
                n.stg = r.stg + 3'h1;
                if (r.stg == STAGE_LAST) begin
                    n.db[r.i] = n.dl;
                    n.ks = (r.ks == FRAME_LAST) ? 8'h00 : r.ks + 8'h01;
                    if (r.i == SUB_LAST) begin
                        n.i = '0; // R2
                        n.lam = LAG_MIN;
                        n.acc = '0;
                        n.st = ST_CORR;
                    end else begin
                        n.i = r.i + 6'h01;
                        n.rdy = 1'b1;
                        n.st = ST_IDLE;
                    end
                end
            end
            // one product per cycle over 40 samples and 81 lags
            ST_CORR: begin
                p = $signed(r.db[r.i]) * $signed(r.hist[hx[6:0]]);
                sum = $signed(r.acc) + 40'(p); // R3
                if (r.i == SUB_LAST) begin
                    if (r.lam == LAG_MIN || sum > $signed(r.best)) begin
                        n.best = sum; // R4 R19
                        n.lag = r.lam; // R20
                    end
                    n.acc = '0;
                    n.i = '0;
                    if (r.lam == LAG_MAX) begin
                        n.st = ST_ENER;
                    end else begin
                        n.lam = r.lam + 7'h01;
                    end
                end else begin
                    n.acc = sum;
                    n.i = r.i + 6'h01;
                end
            end
            ST_ENER: begin
                p = $signed(r.hist[hx[6:0]]) * $signed(r.hist[hx[6:0]]);
                n.acc = 40'($signed(r.acc) + 40'(p)); // R5
                n.i = r.i + 6'h01;
                if (r.i == SUB_LAST) begin
                    n.i = '0;
                    n.st = ST_QUANT;
                end
            end
            // gain = best / energy, compared by cross-multiplying
            ST_QUANT: begin
                rr = 44'($signed(r.best));
                ss = 44'($signed(r.acc));
                if (rr * DEC0_R <= ss * DEC0_S) begin
                    n.gc = 2'h0; // R5 R8
                end else if (rr * DEC1_R <= ss * DEC1_S) begin
                    n.gc = 2'h1;
                end else if (rr * DEC2_R <= ss * DEC2_S) begin
                    n.gc = 2'h2;
                end else begin
                    n.gc = 2'h3;
                end
                n.st = ST_LTPF;
            end
            ST_LTPF: begin
                p = gain_lvl(r.gc) * $signed(r.hist[hx[6:0]]); // R9 R11
                est = sat16(48'(p >>> GAIN_SHIFT));
                ev = sat16(48'($signed(r.db[r.i])) - 48'($signed(est))); // R10
                n.eb[r.i] = ev;
                n.db[r.i] = sat16(48'($signed(ev)) + 48'($signed(est))); // R12
                n.i = r.i + 6'h01;
                if (r.i == SUB_LAST) begin
                    n.hist = {n.db, r.hist[119:40]}; // R6 R12
                    n.i = '0;
                    n.t = '0;
                    n.ph = '0;
                    n.acc = '0;
                    n.en = '0;
                    n.st = ST_WEIGHT;
                end
            end
            // block filter: eleven products per output sample
            ST_WEIGHT: begin
                ix = 8'(r.i) + TAP_CENTRE - 8'(r.t);
                if (ix <= 8'(SUB_LAST)) begin
                    p = tap(r.t) * $signed(r.eb[ix[5:0]]); // R13 R14
                end
                sum = $signed(r.acc) + 40'(p);
                n.acc = sum;
                n.t = r.t + 4'h1;
                if (r.t == TAP_LAST) begin
                    xv = sat16(48'(sum >>> TAP_SHIFT)); // R13
                    n.xb[r.i] = xv;
                    q = $signed(xv) * $signed(xv);
                    case (r.ph)
                        2'h0: begin
                            if (r.i <= GRID_SPAN) begin
                                n.en[0] = r.en[0] + 40'(q); // R15
                            end
                            if (r.i >= GRID_STRIDE) begin
                                n.en[3] = r.en[3] + 40'(q);
                            end
                        end
                        2'h1: n.en[1] = r.en[1] + 40'(q);
                        default: n.en[2] = r.en[2] + 40'(q);
                    endcase
                    n.ph = (r.ph == 2'h2) ? 2'h0 : r.ph + 2'h1;
                    n.acc = '0;
                    n.t = '0;
                    n.i = r.i + 6'h01;
                    if (r.i == SUB_LAST) begin
                        for (int m = 1; m < 4; m++) begin
                            if (n.en[m] > n.en[g]) begin
                                g = 2'(m); // R16 R19
                            end
                        end
                        n.grid = g; // R17
                        n.param_v = 1'b1;
                        n.i = '0;
                        n.st = ST_OUT;
                    end
                end
            end
            ST_OUT: begin
                n.pv = 1'b1;
                n.pdata = r.xb[6'(r.grid) + 6'(r.i) * GRID_STRIDE]; // R15 R16
                n.plast = (r.i == 6'(GRID_LAST));
                n.i = r.i + 6'h01;
                if (r.i == 6'(GRID_LAST)) begin
                    n.i = '0;
                    n.rdy = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            default: n.st = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            r <= '0;
            r.rdy <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs come straight from state flops
    assign SAMPLE_READY = r.rdy;
    assign PARAM_VALID = r.param_v;
    assign LAG_CODE = r.lag; // R7 R20
    assign GAIN_CODE = r.gc;
    assign GRID_CODE = r.grid;
    assign PULSE_VALID = r.pv;
    assign PULSE_LAST = r.plast;
    assign PULSE_DATA = r.pdata;

    // checks on the datapath
    a_lag_range: assert property (@(posedge CLOCK) disable iff (RST) // R4
        PARAM_VALID |-> LAG_CODE >= LAG_MIN && LAG_CODE <= LAG_MAX)
        else $error("lag out of range");
    a_corr_end: assert property (@(posedge CLOCK) disable iff (RST) // R3
        (r.st == ST_CORR && r.i == SUB_LAST && r.lam == LAG_MAX) |=> r.st == ST_ENER)
        else $error("correlation did not stop at top lag");
    a_sub_start: assert property (@(posedge CLOCK) disable iff (RST) // R2
        (r.st == ST_LAT && $past(r.st) != ST_LAT) ##7 (r.i == SUB_LAST)
        |=> r.st == ST_CORR && r.lam == LAG_MIN)
        else $error("subsegment end did not start prediction");
    a_gain_zero: assert property (@(posedge CLOCK) disable iff (RST) // R8
        (r.st == ST_QUANT && $signed(r.best) <= 0) |=> GAIN_CODE == 2'h0)
        else $error("non-positive correlation gave nonzero gain code");
    a_gain_top: assert property (@(posedge CLOCK) disable iff (RST) // R8
        (r.st == ST_QUANT && $signed(r.best) > 0
         && 44'($signed(r.best)) * DEC2_R > 44'($signed(r.acc)) * DEC2_S)
        |=> GAIN_CODE == 2'h3)
        else $error("large gain not coded as three");
    a_hist_feed: assert property (@(posedge CLOCK) disable iff (RST) // R6
        (r.st == ST_LTPF && r.i == SUB_LAST) |=> r.hist[79:40] == $past(r.hist[119:80]))
        else $error("history not carried over");
    a_pulse_count: assert property (@(posedge CLOCK) disable iff (RST) // R15
        PULSE_LAST |-> (PULSE_VALID && r.run == GRID_LAST) ##1 !PULSE_VALID)
        else $error("grid not thirteen pulses");
    a_pulse_start: assert property (@(posedge CLOCK) disable iff (RST) // R15
        (PARAM_VALID || (PULSE_VALID && !PULSE_LAST)) |=> PULSE_VALID)
        else $error("pulse run broken before the last pulse");
    a_grid_best: assert property (@(posedge CLOCK) disable iff (RST) // R16
        PARAM_VALID |-> r.en[GRID_CODE] >= r.en[0] && r.en[GRID_CODE] >= r.en[1]
            && r.en[GRID_CODE] >= r.en[2] && r.en[GRID_CODE] >= r.en[3])
        else $error("selected grid not the most energetic");
    a_ready_back: assert property (@(posedge CLOCK) disable iff (RST) // R1
        (SAMPLE_VALID && SAMPLE_READY && r.i != SUB_LAST) |=> !SAMPLE_READY [*8]
        ##1 SAMPLE_READY)
        else $error("lattice did not take eight stages");

    c_params: cover property (@(posedge CLOCK) disable iff (RST) PARAM_VALID);
    c_gain_max: cover property (@(posedge CLOCK) PARAM_VALID && GAIN_CODE == 2'h3);
    c_grid_last: cover property (@(posedge CLOCK) PARAM_VALID && GRID_CODE == 2'h3);
    c_lag_top: cover property (@(posedge CLOCK) PARAM_VALID && LAG_CODE == LAG_MAX);
endmodule

// [verification/sre_sink.sv]
// downstream model: collects subsegment codes and the selected pulse sequence
`timescale 1ns/1ps
module sre_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic param_valid,
    input wire logic [6:0] lag_code,
    input wire logic [1:0] gain_code,
    input wire logic [1:0] grid_code,
    input wire logic pulse_valid,
    input wire logic pulse_last,
    input wire sre_pkg::sre_smp_t pulse_data,
    output logic [6:0] lag_q,
    output logic [1:0] gain_q,
    output logic [1:0] grid_q,
    output sre_pkg::sre_smp_t pulse_q [13],
    output logic [4:0] cnt_q,
    output logic last_q
);
    import sre_pkg::*;
    // codes are taken only at the strobe; pulses fill in arrival order, no back-pressure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lag_q <= 7'h00;
            gain_q <= 2'h0;
            grid_q <= 2'h0;
            cnt_q <= 5'h00;
            last_q <= 1'b0;
        end else if (param_valid) begin
            lag_q <= lag_code;
            gain_q <= gain_code;
            grid_q <= grid_code;
            cnt_q <= 5'h00;
            last_q <= 1'b0;
        end else if (pulse_valid) begin
            if (cnt_q < 5'h0D) begin
                pulse_q[cnt_q] <= pulse_data;
            end
            cnt_q <= cnt_q + 5'h01;
            last_q <= pulse_last && (cnt_q == 5'h0C);
        end
    end
endmodule

// [verification/testbench.sv]
// self-checking bench for the speech residual encoder
`timescale 1ns/1ps
module testbench;
    import sre_pkg::*;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic SAMPLE_VALID = 1'b0;
    sre_smp_t SAMPLE_IN = 16'sh0000;
    logic COEF_WE = 1'b0;
    logic [1:0] COEF_SET = 2'h0;
    logic [2:0] COEF_IDX = 3'h0;
    sre_smp_t COEF_DATA = 16'sh0000;
    logic SAMPLE_READY, PARAM_VALID, PULSE_VALID, PULSE_LAST;
    logic [6:0] LAG_CODE, got_lag;
    logic [1:0] GAIN_CODE, GRID_CODE, got_gain, got_grid;
    sre_smp_t PULSE_DATA;
    sre_smp_t got_pulse [13];
    logic [4:0] got_cnt;
    logic got_last;
    int mismatches = 0;
    int check_count = 0;
    int s_vec [40];
    int e_vec [40];

    // free-running 25 MHz clock
    initial begin
        forever #20 CLOCK = ~CLOCK;
    end

    sre_speech_residual_encoder u_dut (
        .CLOCK(CLOCK), .RST(RST), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_IN(SAMPLE_IN),
        .COEF_WE(COEF_WE), .COEF_SET(COEF_SET), .COEF_IDX(COEF_IDX), .COEF_DATA(COEF_DATA),
        .SAMPLE_READY(SAMPLE_READY), .PARAM_VALID(PARAM_VALID), .LAG_CODE(LAG_CODE),
        .GAIN_CODE(GAIN_CODE), .GRID_CODE(GRID_CODE), .PULSE_VALID(PULSE_VALID),
        .PULSE_LAST(PULSE_LAST), .PULSE_DATA(PULSE_DATA)
    );

    sre_sink u_sink (
        .clk(CLOCK), .rst(RST), .param_valid(PARAM_VALID), .lag_code(LAG_CODE),
        .gain_code(GAIN_CODE), .grid_code(GRID_CODE), .pulse_valid(PULSE_VALID),
        .pulse_last(PULSE_LAST), .pulse_data(PULSE_DATA), .lag_q(got_lag),
        .gain_q(got_gain), .grid_q(got_grid), .pulse_q(got_pulse), .cnt_q(got_cnt),
        .last_q(got_last)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge CLOCK);
        RST <= 1'b1;
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        check(16'(SAMPLE_READY), 16'h0001);
        check(16'(PARAM_VALID), 16'h0000);
    endtask

    task automatic wr_coef(input logic [1:0] set, input logic [2:0] idx, input sre_smp_t v);
        @(posedge CLOCK);
        COEF_WE <= 1'b1;
        COEF_SET <= set;
        COEF_IDX <= idx;
        COEF_DATA <= v;
    endtask

    // offer one sample once ready is seen, hold it over the taking edge
    task automatic send_sample(input sre_smp_t v);
        int n;
        n = 0;
        @(posedge CLOCK);
        while (SAMPLE_READY !== 1'b1 && n < 5000) begin
            @(posedge CLOCK);
            n++;
        end
        check(16'(SAMPLE_READY), 16'h0001);
        SAMPLE_VALID <= 1'b1;
        SAMPLE_IN <= v;
        @(posedge CLOCK);
        SAMPLE_VALID <= 1'b0;
    endtask

    task automatic clear();
        for (int k = 0; k < 40; k++) begin
            s_vec[k] = 0;
            e_vec[k] = 0;
        end
    endtask

    // one subsegment in, then wait for the whole result to leave
    task automatic feed_sub();
        int n;
        n = 0;
        for (int k = 0; k < 40; k++) send_sample(16'(s_vec[k]));
        @(posedge CLOCK);
        while (SAMPLE_READY !== 1'b1 && n < 6000) begin
            @(posedge CLOCK);
            n++;
        end
        check(16'(SAMPLE_READY), 16'h0001);
        repeat (2) @(posedge CLOCK);
    endtask

    // block filter of e_vec, then the strongest stride-3 grid, first one on ties
    function automatic void ref_grid(output logic [1:0] g, output sre_smp_t p [13]);
        int h [11] = '{-134, -374, 0, 2054, 5741, 8192, 5741, 2054, 0, -374, -134};
        int x [40];
        int acc;
        longint en;
        longint best;
        best = -1;
        g = 2'h0;
        for (int k = 0; k < 40; k++) begin
            acc = 0;
            for (int i = 0; i < 11; i++) begin
                if (k + 5 - i >= 0 && k + 5 - i <= 39) acc += h[i] * e_vec[k + 5 - i];
            end
            acc = acc >>> 13;
            x[k] = acc > 32767 ? 32767 : (acc < -32768 ? -32768 : acc);
        end
        for (int m = 0; m < 4; m++) begin
            en = 0;
            for (int i = 0; i < 13; i++) en += longint'(x[m + 3 * i]) * x[m + 3 * i];
            if (en > best) begin
                best = en;
                g = 2'(m);
            end
        end
        for (int i = 0; i < 13; i++) p[i] = 16'(x[g + 3 * i]);
    endfunction

    task automatic expect_sub(input logic [6:0] lag, input logic [1:0] gain);
        logic [1:0] g;
        sre_smp_t p [13];
        ref_grid(g, p);
        check(16'(got_lag), 16'(lag));
        check(16'(got_gain), 16'(gain));
        check(16'(got_grid), 16'(g));
        check(16'(got_cnt), 16'h000D);
        check(16'(got_last), 16'h0001);
        for (int i = 0; i < 13; i++) check(got_pulse[i], p[i]);
    endtask

    // the second coefficient set carries 0.5 in stages 0 and 1; the other three sets carry -1.0 in stage 0 only
    task automatic t_lattice();
        do_reset();
        for (int s = 0; s < 4; s++) wr_coef(2'(s), 3'h0, (s == 1) ? 16'sh4000 : 16'sh8000);
        wr_coef(2'h1, 3'h1, 16'sh4000);
        @(posedge CLOCK);
        COEF_WE <= 1'b0;
        clear();
        s_vec[20] = 1000;
        e_vec[20] = 1000;
        e_vec[21] = 750;
        e_vec[22] = 500;
        feed_sub();
        expect_sub(7'h28, 2'h0);
    endtask

    // pitch history from subsegment 0 predicts subsegment 1 at lag 50, gain swept
    task automatic t_ltp();
        int amp [5] = '{200, 500, 800, 801, 1000};
        int lvl [4];
        int est;
        lvl = '{int'(GAIN_LVL0), int'(GAIN_LVL1), int'(GAIN_LVL2), int'(GAIN_LVL3)};
        for (int c = 0; c < 5; c++) begin
            do_reset();
            clear();
            s_vec[20] = 1000;
            e_vec[20] = 1000;
            feed_sub();
            expect_sub(7'h28, 2'h0);
            clear();
            s_vec[30] = amp[c];
            est = (lvl[c < 4 ? c : 3] * 1000) >>> 15;
            e_vec[30] = amp[c] - est;
            feed_sub();
            expect_sub(7'h32, 2'(c < 4 ? c : 3));
        end
        // lag 40 ties lag 90 only if history holds the rebuilt sample, not the residual
        clear();
        s_vec[30] = 1000;
        e_vec[30] = 1000 - est;
        feed_sub();
        expect_sub(7'h28, 2'h3);
    endtask

    initial begin
        do_reset();
        t_lattice();
        t_ltp();
        test_done();
    end

    // hang guard: twelve subsegments take about 52000 cycles
    initial begin
        repeat (80000) @(posedge CLOCK);
        mismatches++;
        test_done();
    end
endmodule
